//--- shared/bces_consts.svh
// Constants of the bus cycle event sequencer: register map, field positions, sizes.
// Assumes inclusion by bare name from the package and the design modules.
// Behaviour
// - Data and probe comparators hold a value and mask; mask 1 ignores that bit.
// - A status comparator matches only when all selected qualifiers hold together.
// - Qualifiers cover direction, width, space, segment, cycle type, DMA, target, flush, depth.
// - Status value and mask are each stored and read back as 32-bit words.
// - Cycle type code sits in status bits 8 to 10; read-memory is 101.
// - Segment field starts at status bit 14; zero there means the NMI cycle.
// - Status bit 2 is one when the cycle goes to the target, not overlay.
// - Group 1 limit loads the counter; count action decrements; reaching the limit fires.
// - Group switch keeps the counter; only reload action loads the active group limit.
// - Four groups, one active; a statement without group number belongs to group 1.
// - A matching statement performs every action in its list.
// - Actions are break, count, interrupt, group switch, reload, trigger, toggles, trace.
// - When count and toggle-count are both requested, toggle-count is ignored.
// - Toggle-trace inverts tracing; every later cycle is stored until toggled off or break.
// - Negation inverts a comparator; NOT before AND before OR.
// - An address range matches inside, or outside when set to outside mode.
`ifndef BCES_CONSTS_SVH
`define BCES_CONSTS_SVH

`define BCES_GROUPS 4
`define BCES_GRP_WORDS 20
`define BCES_STMTS 4
`define BCES_CMP_WORDS 12

// Per-group word indices; byte address is {group, index, 2'b00}.
`define BCES_W_AC1_LO 5'h00
`define BCES_W_AC1_HI 5'h01
`define BCES_W_AC2_LO 5'h02
`define BCES_W_AC2_HI 5'h03
`define BCES_W_DATA1 5'h04
`define BCES_W_DATA2 5'h05
`define BCES_W_S1_VAL 5'h06
`define BCES_W_S1_MASK 5'h07
`define BCES_W_S2_VAL 5'h08
`define BCES_W_S2_MASK 5'h09
`define BCES_W_PROBE 5'h0a
`define BCES_W_LIMIT 5'h0b
`define BCES_W_TERM0 5'h0c
`define BCES_W_ACT0 5'h10

// Global registers.
`define BCES_A_CTRL 10'h200
`define BCES_A_STAT 10'h204
`define BCES_A_IRQ_STAT 10'h208
`define BCES_A_IRQ_MASK 10'h20c

// Range end word: bit 24 selects outside_range_mode.
`define BCES_OUTSIDE_BIT 24

// Status word layout.
`define BCES_ST_WRITE 0
`define BCES_ST_BYTE 1
`define BCES_ST_TARGET 2
`define BCES_ST_IO 3
`define BCES_ST_QDEPTH 4
`define BCES_ST_QFLUSH 7
`define BCES_ST_TYPE 8
`define BCES_ST_DMA 12
`define BCES_ST_SEGMENT 14
`define BCES_TYPE_READ_MEM 3'h5

// Action bits inside an action word.
`define BCES_OP_HALT 0
`define BCES_OP_COUNT 1
`define BCES_OP_SINT 2
`define BCES_OP_GRP 3
`define BCES_OP_RELOAD 4
`define BCES_OP_TRIG 5
`define BCES_OP_TCOUNT 6
`define BCES_OP_TTRACE 7
`define BCES_OP_STORE 8

// Interrupt status bits.
`define BCES_IRQ_HALT 0
`define BCES_IRQ_SINT 1
`define BCES_IRQ_LIMIT 2
`define BCES_IRQ_GRP 3

`define BCES_CNT_W 16

`endif

//--- shared/bces_pkg.sv
// Types of the bus cycle event sequencer.
// Assumes bces_consts.svh on the include path.
`include "bces_consts.svh"

package bces_pkg;

	typedef enum logic [1:0] {BCES_IDLE, BCES_ARMED, BCES_BROKEN} bces_run_t;

	typedef struct packed {
		logic [1:0] target;
		logic [8:0] op;
	} bces_act_t;

	typedef struct packed {
		logic [`BCES_GROUPS-1:0][`BCES_GRP_WORDS-1:0][31:0] cfg;
		bces_run_t run;
		logic [1:0] group;
		logic trace_on;
		logic count_on;
		logic [2:0][15:0] probe_sync;
		logic [15:0] probe;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic [31:0] rdata;
		logic halt;
		logic sint;
		logic trig;
		logic store;
	} bces_seq_t;

	typedef struct packed {
		logic [`BCES_CNT_W-1:0] val;
	} bces_cnt_t;

endpackage

//--- shared/bces_link_if.sv
// Signals between the sequencer and its comparator and counter modules.
// Assumes one clock domain; all members are driven combinationally or from flip-flops.
`timescale 1ns/1ps
`include "bces_consts.svh"

interface bces_link_if;
	logic [`BCES_CMP_WORDS-1:0][31:0] cmp_cfg;
	logic [23:0] addr;
	logic [15:0] data;
	logic [31:0] status;
	logic [15:0] probe;
	logic [6:0] hits;
	logic cnt_load;
	logic [`BCES_CNT_W-1:0] cnt_limit;
	logic cnt_dec;
	logic [`BCES_CNT_W-1:0] cnt_val;
	logic cnt_zero;

	modport seq (output cmp_cfg, addr, data, status, probe, cnt_load, cnt_limit, cnt_dec,
		input hits, cnt_val, cnt_zero);
	modport match (input cmp_cfg, addr, data, status, probe, output hits);
	modport count (input cnt_load, cnt_limit, cnt_dec, output cnt_val, cnt_zero);
endinterface

//--- src/bces_match.sv
// Comparators of the active event group, evaluated without state.
// Assumes the sequencer presents the active group's configuration and the current cycle.
`timescale 1ns/1ps
`include "bces_consts.svh"

module bces_match (
	// Link to the sequencer.
	bces_link_if.match lnk
);

	function automatic logic masked_eq(input logic [31:0] val, input logic [31:0] ref_val,
		input logic [31:0] mask);
		return ((val ^ ref_val) & ~mask) == 32'h0000_0000;
	endfunction

	function automatic logic in_range(input logic [23:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		logic in_span;
		in_span = (a >= lo[23:0]) && (a <= hi[23:0]);
		return hi[`BCES_OUTSIDE_BIT] ? !in_span : in_span;
	endfunction

	assign lnk.hits[0] = in_range(lnk.addr, lnk.cmp_cfg[`BCES_W_AC1_LO],
		lnk.cmp_cfg[`BCES_W_AC1_HI]);
	assign lnk.hits[1] = in_range(lnk.addr, lnk.cmp_cfg[`BCES_W_AC2_LO],
		lnk.cmp_cfg[`BCES_W_AC2_HI]);
	// Data and probe words hold the value low and the dont_care_mask high.
	assign lnk.hits[2] = masked_eq({16'h0000, lnk.data},
		{16'h0000, lnk.cmp_cfg[`BCES_W_DATA1][15:0]},
		{16'h0000, lnk.cmp_cfg[`BCES_W_DATA1][31:16]});
	assign lnk.hits[3] = masked_eq({16'h0000, lnk.data},
		{16'h0000, lnk.cmp_cfg[`BCES_W_DATA2][15:0]},
		{16'h0000, lnk.cmp_cfg[`BCES_W_DATA2][31:16]});
	// Every unmasked qualifier bit must agree at once.
	assign lnk.hits[4] = masked_eq(lnk.status, lnk.cmp_cfg[`BCES_W_S1_VAL],
		lnk.cmp_cfg[`BCES_W_S1_MASK]);
	assign lnk.hits[5] = masked_eq(lnk.status, lnk.cmp_cfg[`BCES_W_S2_VAL],
		lnk.cmp_cfg[`BCES_W_S2_MASK]);
	assign lnk.hits[6] = masked_eq({16'h0000, lnk.probe},
		{16'h0000, lnk.cmp_cfg[`BCES_W_PROBE][15:0]},
		{16'h0000, lnk.cmp_cfg[`BCES_W_PROBE][31:16]});

endmodule

//--- src/bces_count.sv
// Hardware count limit counter: load, saturating decrement, zero flag.
// Assumes load and decrement come from the sequencer on the same clock.
`timescale 1ns/1ps
`include "bces_consts.svh"

module bces_count (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Link to the sequencer.
	bces_link_if.count lnk
);

	bces_pkg::bces_cnt_t s_r;
	bces_pkg::bces_cnt_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		if (lnk.cnt_load)
		begin
			s_nxt.val = lnk.cnt_limit;
		end
		else if (lnk.cnt_dec && (s_r.val != '0))
		begin
			s_nxt.val = s_r.val - 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign lnk.cnt_val = s_r.val;
	assign lnk.cnt_zero = (s_r.val == '0);

endmodule

//--- src/bces_sequencer.sv
// Event sequencer top: register port, four event groups, action execution, interrupt.
// Assumes bus cycle inputs are on clk with cyc_valid one cycle per bus cycle; probe pins
// are asynchronous.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "bces_consts.svh"

module bces_sequencer (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Register port.
	input wire logic [9:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Observed bus cycle.
	input wire logic cyc_valid,
	input wire logic [23:0] cyc_addr,
	input wire logic [15:0] cyc_data,
	input wire logic cyc_write,
	input wire logic cyc_byte,
	input wire logic cyc_io,
	input wire logic cyc_target,
	input wire logic cyc_qflush,
	input wire logic cyc_dma,
	input wire logic [2:0] cyc_qdepth,
	input wire logic [2:0] cyc_type,
	input wire logic [1:0] cyc_segment,
	// Logic probe pins.
	input wire logic [15:0] probe_in,
	// Action outputs.
	output logic break_req,
	output logic sint_req,
	output logic trigger_out,
	output logic trace_store,
	output logic [1:0] active_group,
	output logic irq
);

	bces_pkg::bces_seq_t s_r;
	bces_pkg::bces_seq_t s_nxt;
	bces_pkg::bces_act_t act;
	logic [31:0] status_word;
	logic [7:0] hits;
	logic fire;
	logic arm;
	logic [`BCES_CNT_W-1:0] grp_limit;
	logic [`BCES_CNT_W-1:0] first_limit;

	bces_link_if lnk ();

	bces_match u_match (
		.lnk(lnk.match)
	);

	bces_count u_count (
		.clk(clk),
		.rst(rst),
		.lnk(lnk.count)
	);

	// A term names comparators in its low byte and the negated ones in its high byte.
	function automatic logic term_hit(input logic [15:0] t, input logic [7:0] h);
		return (t[7:0] != 8'h00) && (&((h ^ t[15:8]) | ~t[7:0]));
	endfunction

	// Each statement is two AND terms joined by OR; actions of all matches are merged.
	function automatic bces_pkg::bces_act_t eval_group(
		input logic [`BCES_GRP_WORDS-1:0][31:0] gcfg, input logic [7:0] h);
		bces_pkg::bces_act_t acc;
		logic [31:0] tw;
		logic [31:0] aw;
		logic got;
		acc = '0;
		got = 1'b0;
		for (int st = 0; st < `BCES_STMTS; st++)
		begin
			tw = gcfg[`BCES_W_TERM0 + st];
			aw = gcfg[`BCES_W_ACT0 + st];
			if (term_hit(tw[15:0], h) || term_hit(tw[31:16], h))
			begin
				acc.op = acc.op | aw[8:0];
				if (aw[`BCES_OP_GRP] && !got)
				begin
					acc.target = aw[10:9];
					got = 1'b1;
				end
			end
		end
		if (acc.op[`BCES_OP_COUNT])
		begin
			acc.op[`BCES_OP_TCOUNT] = 1'b0;
		end
		return acc;
	endfunction

	function automatic logic [31:0] build_status(input logic wr, input logic by,
		input logic tg, input logic io, input logic [2:0] qd, input logic qf,
		input logic [2:0] ty, input logic dm, input logic [1:0] sg);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`BCES_ST_WRITE] = wr;
		w[`BCES_ST_BYTE] = by;
		w[`BCES_ST_TARGET] = tg;
		w[`BCES_ST_IO] = io;
		w[`BCES_ST_QDEPTH +: 3] = qd;
		w[`BCES_ST_QFLUSH] = qf;
		w[`BCES_ST_TYPE +: 3] = ty;
		w[`BCES_ST_DMA] = dm;
		w[`BCES_ST_SEGMENT +: 2] = sg;
		return w;
	endfunction

	assign status_word = build_status(cyc_write, cyc_byte, cyc_target, cyc_io, cyc_qdepth,
		cyc_qflush, cyc_type, cyc_dma, cyc_segment);

	// Only the active group's comparators reach the match logic.
	always_comb
	begin
		for (int i = 0; i < `BCES_CMP_WORDS; i++)
		begin
			lnk.cmp_cfg[i] = s_r.cfg[s_r.group][i];
		end
	end

	assign lnk.addr = cyc_addr;
	assign lnk.data = cyc_data;
	assign lnk.status = status_word;
	assign lnk.probe = s_r.probe;
	assign hits = {lnk.cnt_zero, lnk.hits};
	assign act = eval_group(s_r.cfg[s_r.group], hits);
	assign fire = (s_r.run == bces_pkg::BCES_ARMED) && cyc_valid;
	assign arm = reg_wr && (reg_addr == `BCES_A_CTRL) && reg_wdata[0];
	assign grp_limit = s_r.cfg[s_r.group][`BCES_W_LIMIT][`BCES_CNT_W-1:0];
	assign first_limit = s_r.cfg[0][`BCES_W_LIMIT][`BCES_CNT_W-1:0];

	// Arming loads group 1's limit; a reload action loads the active group's limit.
	assign lnk.cnt_load = arm || (fire && act.op[`BCES_OP_RELOAD]);
	assign lnk.cnt_limit = arm ? first_limit : grp_limit;
	assign lnk.cnt_dec = fire && (act.op[`BCES_OP_COUNT] || s_r.count_on);

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.halt = 1'b0;
		s_nxt.sint = 1'b0;
		s_nxt.trig = 1'b0;
		s_nxt.store = 1'b0;
		s_nxt.rdata = 32'h0000_0000;

		// Probe pins: three stages, accepted once the second and third agree.
		s_nxt.probe_sync[0] = probe_in;
		s_nxt.probe_sync[1] = s_r.probe_sync[0];
		s_nxt.probe_sync[2] = s_r.probe_sync[1];
		if (s_r.probe_sync[1] == s_r.probe_sync[2])
		begin
			s_nxt.probe = s_r.probe_sync[2];
		end

		if (fire)
		begin
			s_nxt.trig = act.op[`BCES_OP_TRIG];
			s_nxt.sint = act.op[`BCES_OP_SINT];
			s_nxt.store = act.op[`BCES_OP_STORE] || s_r.trace_on;
			if (act.op[`BCES_OP_TTRACE])
			begin
				s_nxt.trace_on = !s_r.trace_on;
			end
			if (act.op[`BCES_OP_TCOUNT])
			begin
				s_nxt.count_on = !s_r.count_on;
			end
			if (act.op[`BCES_OP_GRP])
			begin
				s_nxt.group = act.target;
			end
			if (act.op[`BCES_OP_HALT])
			begin
				s_nxt.halt = 1'b1;
				s_nxt.trace_on = 1'b0;
				s_nxt.run = bces_pkg::BCES_BROKEN;
			end
		end

		// Register writes.
		if (reg_wr)
		begin
			if (!reg_addr[9])
			begin
				if (reg_addr[6:2] < 5'(`BCES_GRP_WORDS))
				begin
					s_nxt.cfg[reg_addr[8:7]][reg_addr[6:2]] = reg_wdata;
				end
			end
			else
			begin
				case (reg_addr)
					`BCES_A_CTRL:
					begin
						if (reg_wdata[0])
						begin
							s_nxt.run = bces_pkg::BCES_ARMED;
							s_nxt.group = 2'h0;
							s_nxt.trace_on = 1'b0;
							s_nxt.count_on = 1'b0;
						end
						else
						begin
							s_nxt.run = bces_pkg::BCES_IDLE;
						end
					end
					`BCES_A_IRQ_STAT:
					begin
						s_nxt.irq_stat = s_r.irq_stat & ~reg_wdata[3:0];
					end
					`BCES_A_IRQ_MASK:
					begin
						s_nxt.irq_mask = reg_wdata[3:0];
					end
					default:
					begin
						s_nxt.irq_mask = s_r.irq_mask;
					end
				endcase
			end
		end

		// Events set sticky bits after the clear so that a same-cycle event wins.
		if (fire)
		begin
			if (act.op[`BCES_OP_HALT])
				s_nxt.irq_stat[`BCES_IRQ_HALT] = 1'b1;
			if (act.op[`BCES_OP_SINT])
				s_nxt.irq_stat[`BCES_IRQ_SINT] = 1'b1;
			if (lnk.cnt_zero)
				s_nxt.irq_stat[`BCES_IRQ_LIMIT] = 1'b1;
			if (act.op[`BCES_OP_GRP])
				s_nxt.irq_stat[`BCES_IRQ_GRP] = 1'b1;
		end

		// Register reads answer in the next cycle only.
		if (reg_rd)
		begin
			if (!reg_addr[9])
			begin
				if (reg_addr[6:2] < 5'(`BCES_GRP_WORDS))
				begin
					s_nxt.rdata = s_r.cfg[reg_addr[8:7]][reg_addr[6:2]];
				end
			end
			else
			begin
				case (reg_addr)
					`BCES_A_CTRL:
						s_nxt.rdata = {30'h0000_0000, s_r.run};
					`BCES_A_STAT:
						s_nxt.rdata = {lnk.cnt_val, 12'h000, s_r.count_on, s_r.trace_on,
							s_r.group};
					`BCES_A_IRQ_STAT:
						s_nxt.rdata = {28'h000_0000, s_r.irq_stat};
					`BCES_A_IRQ_MASK:
						s_nxt.rdata = {28'h000_0000, s_r.irq_mask};
					default:
						s_nxt.rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.run <= bces_pkg::BCES_IDLE;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata = s_r.rdata;
	assign break_req = s_r.halt;
	assign sint_req = s_r.sint;
	assign trigger_out = s_r.trig;
	assign trace_store = s_r.store;
	assign active_group = s_r.group;
	assign irq = |(s_r.irq_stat & s_r.irq_mask);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_break_halts: assert property (break_req |-> s_r.run == bces_pkg::BCES_BROKEN
		&& !s_r.trace_on)
		else $error("break did not halt and stop tracing");

	chk_toggle_ignored: assert property (fire && act.op[`BCES_OP_COUNT] && !arm |=>
		s_r.count_on == $past(s_r.count_on))
		else $error("toggle-count acted beside count");

	chk_group_switch: assert property (fire && act.op[`BCES_OP_GRP] && !reg_wr |=>
		active_group == $past(act.target))
		else $error("group switch went to wrong group");

	chk_count_step: assert property (fire && act.op[`BCES_OP_COUNT] && !lnk.cnt_load &&
		!lnk.cnt_zero |=> lnk.cnt_val == $past(lnk.cnt_val) - 16'h0001)
		else $error("count action did not decrement once");

	chk_reload_limit: assert property (fire && act.op[`BCES_OP_RELOAD] && !arm |=>
		lnk.cnt_val == $past(grp_limit))
		else $error("reload did not load active group limit");

	chk_switch_keeps: assert property (fire && act.op[`BCES_OP_GRP] && !lnk.cnt_load &&
		!lnk.cnt_dec |=> $stable(lnk.cnt_val))
		else $error("group switch changed the counter");

	chk_idle_quiet: assert property (!fire |=> !break_req && !sint_req && !trigger_out)
		else $error("action without an evaluated cycle");

	chk_trace_on_store: assert property (fire && s_r.trace_on |=> trace_store)
		else $error("traced state missed a cycle");

	chk_read_latency: assert property (reg_rd && reg_addr == `BCES_A_IRQ_MASK |=>
		reg_rdata == {28'h000_0000, $past(s_r.irq_mask)})
		else $error("read data not in next cycle");

	chk_arm_loads: assert property (arm ##1 !lnk.cnt_load[*2] |->
		lnk.cnt_val <= $past(first_limit, 2))
		else $error("arming did not load group 1 limit");

	chk_limit_flag: assert property (fire && lnk.cnt_zero |=> s_r.irq_stat[`BCES_IRQ_LIMIT])
		else $error("evaluated cycle at the limit did not raise its flag");

	chk_arm_group: assert property (arm |=> active_group == 2'h0)
		else $error("arming did not select group 1");

	cov_break: cover property (fire && act.op[`BCES_OP_HALT]);
	cov_switch_then_hit: cover property (fire && act.op[`BCES_OP_GRP] ##[1:20] fire &&
		act.op != 9'h000);
	cov_limit_reached: cover property (lnk.cnt_dec ##1 lnk.cnt_zero);
	cov_trace_run: cover property (trace_store [*3]);

endmodule

//--- test/bces_bus_model.sv
// Model of the emulated processor bus and the logic probe pod that feed the sequencer.
// Assumes the sequencer samples every input on the rising edge of clk.
`timescale 1ns/1ps

module bces_bus_model (
	// Clock.
	input wire logic clk,
	// Bus cycle toward the sequencer.
	output logic cyc_valid,
	output logic [23:0] cyc_addr,
	output logic [15:0] cyc_data,
	output logic cyc_write,
	output logic cyc_byte,
	output logic cyc_io,
	output logic cyc_target,
	output logic cyc_qflush,
	output logic cyc_dma,
	output logic [2:0] cyc_qdepth,
	output logic [2:0] cyc_type,
	output logic [1:0] cyc_segment,
	// Probe pins.
	output logic [15:0] probe_in
);
	initial
	begin
		cyc_valid = 1'b0;
		cyc_addr = 24'h000000;
		cyc_data = 16'h0000;
		{cyc_write, cyc_byte, cyc_io, cyc_target, cyc_qflush, cyc_dma} = 6'h00;
		{cyc_qdepth, cyc_type, cyc_segment} = 8'h00;
		probe_in = 16'h0001;
	end

	// One bus cycle; the status word is unpacked with the sequencer's status layout.
	task automatic run_cycle(input logic [15:0] d, input logic [31:0] st);
		@(posedge clk);
		cyc_valid <= 1'b1;
		cyc_addr <= 24'h000100;
		cyc_data <= d;
		cyc_write <= st[0];
		cyc_byte <= st[1];
		cyc_target <= st[2];
		cyc_io <= st[3];
		cyc_qdepth <= st[6:4];
		cyc_qflush <= st[7];
		cyc_type <= st[10:8];
		cyc_dma <= st[12];
		cyc_segment <= st[15:14];
		@(posedge clk);
		cyc_valid <= 1'b0;
		// A released bus does not keep its last value.
		cyc_data <= ~d;
		cyc_addr <= ~cyc_addr;
		#1;
	endtask

	task automatic set_probe(input logic [15:0] v);
		@(posedge clk);
		probe_in <= v;
	endtask
endmodule

//--- test/bces_sequencer_tb_top.sv
// Self-checking bench for the event sequencer: register tasks and bus cycle scenarios.
// Assumes bces_consts.svh on the include path and the bus model as the far side.
`timescale 1ns/1ps
`include "bces_consts.svh"

module bces_sequencer_tb_top;
	logic clk;
	logic rst;
	logic [9:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic cyc_valid, cyc_write, cyc_byte, cyc_io, cyc_target, cyc_qflush, cyc_dma;
	logic [23:0] cyc_addr;
	logic [15:0] cyc_data;
	logic [15:0] probe_in;
	logic [2:0] cyc_qdepth, cyc_type;
	logic [1:0] cyc_segment, active_group;
	logic break_req, sint_req, trigger_out, trace_store, irq;
	int err_count;
	int tests_run;
	logic [3:0][31:0] st_tab = {32'h000045f7, 32'h000004f7, 32'h000005f3, 32'h000005f7};
	logic [3:0] sint_exp = 4'b0001;

	bces_sequencer i_bces_sequencer (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_data(cyc_data),
		.cyc_write(cyc_write), .cyc_byte(cyc_byte), .cyc_io(cyc_io),
		.cyc_target(cyc_target), .cyc_qflush(cyc_qflush), .cyc_dma(cyc_dma),
		.cyc_qdepth(cyc_qdepth), .cyc_type(cyc_type), .cyc_segment(cyc_segment),
		.probe_in(probe_in), .break_req(break_req), .sint_req(sint_req),
		.trigger_out(trigger_out), .trace_store(trace_store),
		.active_group(active_group), .irq(irq));

	bces_bus_model i_bces_bus_model (.clk(clk), .cyc_valid(cyc_valid),
		.cyc_addr(cyc_addr), .cyc_data(cyc_data), .cyc_write(cyc_write),
		.cyc_byte(cyc_byte), .cyc_io(cyc_io), .cyc_target(cyc_target),
		.cyc_qflush(cyc_qflush), .cyc_dma(cyc_dma), .cyc_qdepth(cyc_qdepth),
		.cyc_type(cyc_type), .cyc_segment(cyc_segment), .probe_in(probe_in));

	always #25 clk = ~clk;

	function automatic logic [9:0] ga(input logic [1:0] g, input logic [4:0] i);
		return {1'b0, g, i, 2'b00};
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [9:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, exp, reg_rdata);
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog so that a hang still reaches the report.
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		complete_run();
	end

	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		reg_addr = 10'h000;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		err_count = 0;
		tests_run = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(`BCES_A_CTRL, 32'h0, "ctrl reset");
		rd(`BCES_A_STAT, 32'h0, "stat reset");
		wr(ga(2'h0, 5'h14), 32'h12345678);
		rd(ga(2'h0, 5'h14), 32'h0, "unmapped");
		// Masked data compare, a negated term and a two-action list.
		wr(ga(2'h0, 5'h04), 32'h00ff1234);
		wr(ga(2'h0, `BCES_W_TERM0), 32'h00000004);
		wr(ga(2'h0, `BCES_W_ACT0), 32'h00000120);
		wr(ga(2'h0, `BCES_W_TERM0 + 5'h1), 32'h00000404);
		wr(ga(2'h0, `BCES_W_ACT0 + 5'h1), 32'h00000004);
		// Inside range 1 and not outside-mode range 2 drives the trigger.
		wr(ga(2'h0, `BCES_W_AC1_LO), 32'h000000f0);
		wr(ga(2'h0, `BCES_W_AC1_HI), 32'h000001ff);
		wr(ga(2'h0, `BCES_W_AC2_LO), 32'h000000f0);
		wr(ga(2'h0, `BCES_W_AC2_HI), 32'h010001ff);
		wr(ga(2'h0, `BCES_W_TERM0 + 5'h2), 32'h00000203);
		wr(ga(2'h0, `BCES_W_ACT0 + 5'h2), 32'h00000020);
		wr(`BCES_A_CTRL, 32'h1);
		chk("group", 32'h0, {30'h0, active_group});
		i_bces_bus_model.run_cycle(16'h12ab, 32'h0);
		chk("trig store sint", 32'h6, {29'h0, trigger_out, trace_store, sint_req});
		i_bces_bus_model.run_cycle(16'h22ab, 32'h0);
		chk("trig store sint", 32'h5, {29'h0, trigger_out, trace_store, sint_req});
		// Status compare with the cycle-type, target and segment fields.
		do_reset();
		wr(ga(2'h0, `BCES_W_S1_VAL), 32'h00000504);
		wr(ga(2'h0, `BCES_W_S1_MASK), 32'hffff38fb);
		wr(ga(2'h0, `BCES_W_TERM0), 32'h00000010);
		wr(ga(2'h0, `BCES_W_ACT0), 32'h00000004);
		rd(ga(2'h0, `BCES_W_S1_VAL), 32'h00000504, "s1 value");
		rd(ga(2'h0, `BCES_W_S1_MASK), 32'hffff38fb, "s1 mask");
		wr(`BCES_A_CTRL, 32'h1);
		for (int k = 0; k < 4; k++)
		begin
			i_bces_bus_model.run_cycle(16'h0000, st_tab[k]);
			chk("status sint", {31'h0, sint_exp[k]}, {31'h0, sint_req});
		end
		chk("irq masked", 32'h0, {31'h0, irq});
		rd(`BCES_A_IRQ_STAT, 32'h6, "irq stat");
		wr(`BCES_A_IRQ_MASK, 32'h2);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(`BCES_A_IRQ_STAT, 32'h2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		// Count down to the limit, then break.
		do_reset();
		wr(ga(2'h0, 5'h04), 32'hffff0000);
		wr(ga(2'h0, 5'h0b), 32'h00000002);
		wr(ga(2'h0, `BCES_W_TERM0), 32'h00000004);
		wr(ga(2'h0, `BCES_W_ACT0), 32'h00000042);
		wr(ga(2'h0, `BCES_W_TERM0 + 5'h1), 32'h00000080);
		wr(ga(2'h0, `BCES_W_ACT0 + 5'h1), 32'h00000001);
		wr(`BCES_A_CTRL, 32'h1);
		rd(`BCES_A_STAT, 32'h00020000, "count loaded");
		i_bces_bus_model.run_cycle(16'h5555, 32'h0);
		rd(`BCES_A_STAT, 32'h00010000, "count once");
		i_bces_bus_model.run_cycle(16'haaaa, 32'h0);
		chk("early break", 32'h0, {31'h0, break_req});
		i_bces_bus_model.run_cycle(16'h5555, 32'h0);
		chk("limit break", 32'h1, {31'h0, break_req});
		rd(`BCES_A_CTRL, 32'h2, "broken");
		i_bces_bus_model.run_cycle(16'h5555, 32'h0);
		chk("after break", 32'h0, {31'h0, break_req});
		// Group switch keeps the counter; reload and toggle trace in group 2.
		do_reset();
		wr(ga(2'h0, 5'h04), 32'hffff0000);
		wr(ga(2'h0, 5'h0b), 32'h00000003);
		wr(ga(2'h0, `BCES_W_TERM0), 32'h00000004);
		wr(ga(2'h0, `BCES_W_ACT0), 32'h00000208);
		wr(ga(2'h1, 5'h0b), 32'h00000007);
		wr(ga(2'h1, `BCES_W_PROBE), 32'hfffe0000);
		wr(ga(2'h1, `BCES_W_TERM0), 32'h00000040);
		wr(ga(2'h1, `BCES_W_ACT0), 32'h00000090);
		wr(`BCES_A_CTRL, 32'h1);
		i_bces_bus_model.run_cycle(16'h0000, 32'h0);
		chk("group", 32'h1, {30'h0, active_group});
		rd(`BCES_A_STAT, 32'h00030001, "count kept");
		i_bces_bus_model.run_cycle(16'h0000, 32'h0);
		rd(`BCES_A_STAT, 32'h00030001, "probe high");
		i_bces_bus_model.set_probe(16'h0000);
		repeat (4) @(posedge clk);
		i_bces_bus_model.run_cycle(16'h0000, 32'h0);
		rd(`BCES_A_STAT, 32'h00070005, "reload trace");
		rd(`BCES_A_IRQ_STAT, 32'h00000008, "group irq");
		complete_run();
	end
endmodule
